// [ldp_pkg.sv]
// Constants, register map and state encoding for the LED driver power-up sequencer.
package ldp_pkg;
    // Clock and timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int INIT_UNIT_US = 1000;
    localparam int INIT_UNIT_CYCLES = (INIT_UNIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MIN_PULSE_NS = 1000;
    localparam int MIN_PULSE_CYCLES = MIN_PULSE_NS / CLK_PERIOD_NS;
    localparam int NUM_CH = 12;
    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CONF = 8'h08;
    localparam logic [7:0] ADDR_ENABLE = 8'h0C;
    localparam logic [7:0] ADDR_CURR_BASE = 8'h10;
    localparam logic [7:0] ADDR_DUTY_BASE = 8'h40;
    // Field positions.
    localparam int CTRL_FLAG_CLR_BIT = 0;
    localparam int CTRL_RELOAD_BIT = 1;
    localparam int CTRL_FAULT_CLR_BIT = 2;
    localparam int STAT_POR_BIT = 0;
    localparam int STAT_LOWSUP_BIT = 1;
    localparam int STAT_LOWNOW_BIT = 2;
    localparam int STAT_STATE_LSB = 4;
    localparam int CONF_GAIN_LSB = 0;
    localparam int CONF_FREQ_LSB = 4;
    localparam int CONF_TH_LSB = 8;
    localparam int DUTY_LO_LSB = 0;
    localparam int DUTY_HI_LSB = 4;
    // Reset values for registers without a nonvolatile copy.
    localparam logic [5:0] CURRENT_DEFAULT = 6'h3F;
    localparam logic [7:0] DUTY_HI_DEFAULT = 8'h00;
    localparam logic [3:0] DUTY_LO_DEFAULT = 4'hF;
    // Low-supply threshold scaling onto the supply converter code.
    localparam logic [7:0] LOW_SUP_BASE_CODE = 8'h20;
    localparam logic [7:0] LOW_SUP_STEP_CODE = 8'h08;
    localparam logic [3:0] LOW_SUP_TH_MAX = 4'hE;
    // Current multipliers of the reference gain field.
    localparam logic [9:0] GAIN_X512 = 10'h200;
    localparam logic [9:0] GAIN_X256 = 10'h100;
    localparam logic [9:0] GAIN_X128 = 10'h080;
    localparam logic [9:0] GAIN_X64 = 10'h040;

    typedef enum logic [2:0] {
        LDP_POR = 3'b001,
        LDP_INIT = 3'b010,
        LDP_NORMAL = 3'b100
    } ldp_state_t;

    // Clock cycles per PWM base tick; 256 ticks form one dimming period.
    function automatic logic [9:0] ldp_base_div(input logic [3:0] sel);
        logic [9:0] d;
        d = 10'h3D0;
        case (sel)
            4'h0: d = 10'h3D0;
            4'h1: d = 10'h1E8;
            4'h2: d = 10'h145;
            4'h3: d = 10'h0F4;
            4'h4: d = 10'h0C3;
            4'h5: d = 10'h0A3;
            4'h6: d = 10'h08B;
            4'h7: d = 10'h07A;
            4'h8: d = 10'h062;
            4'h9: d = 10'h051;
            4'hA: d = 10'h03D;
            4'hB: d = 10'h031;
            4'hC: d = 10'h021;
            4'hD: d = 10'h018;
            4'hE: d = 10'h010;
            default: d = 10'h009;
        endcase
        return d;
    endfunction
endpackage

// [ldp_power_seq.sv]
// Power-up sequencer, output configuration and APB register file of the LED driver.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module ldp_power_seq #(
    parameter int INIT_UNIT_CYCLES = ldp_pkg::INIT_UNIT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supplyUvPin,
    input wire logic ldoUvPin,
    input wire logic [3:0] nvInitTimerLength,
    input wire logic [1:0] nvReferenceGain,
    input wire logic [3:0] nvDimmingFrequency,
    input wire logic [3:0] nvLowSupplyThreshold,
    input wire logic [7:0] supplyAdcCode,
    input wire logic supplyAdcValid,
    output logic [ldp_pkg::NUM_CH-1:0] chanDrive,
    output logic [6*ldp_pkg::NUM_CH-1:0] chanCurrentCodeOut,
    output logic [7*ldp_pkg::NUM_CH-1:0] chanCurrentSteps,
    output logic [9:0] currentMultiplier,
    output logic [3:0] dimmingFrequency,
    output logic diagSuppress,
    output logic faultClearPulse,
    output logic faultPinOut,
    output logic faultPinOe
);
    import ldp_pkg::*;

    ldp_state_t state;
    logic [1:0] uvMeta, uvSync, uvLate, uvFilt;
    logic uvActive;
    logic [15:0] unitCnt;
    logic [3:0] unitsLeft;
    logic porFlag, registerReloadCmd, lowSupplyWarningFlag, lowSupplyNow;
    logic [1:0] referenceGainSelect;
    logic [3:0] dimmingFrequencySelect, lowSupplyThreshold, initTimerLength;
    logic [NUM_CH-1:0] channelOutputEnable;
    logic [5:0] channelCurrentCode [NUM_CH];
    logic [7:0] dutyHigh [NUM_CH];
    logic [3:0] dutyLow [NUM_CH];
    logic [9:0] baseCnt;
    logic [7:0] cyclePos;
    logic [3:0] ditherFrame;
    logic baseTick, loadDefaults, wrEn, wrCtrl, clearFlagWrite, faultClearWrite;
    logic addrMapped;
    logic [31:0] readWord;
    logic [7:0] thresholdCode;

    // True when the address falls in one of the twelve per-channel word slots.
    function automatic logic chanHit(input logic [7:0] addr, input logic [7:0] base);
        return (addr >= base) && (addr < base + 8'(4 * NUM_CH)) && (addr[1:0] == 2'b00);
    endfunction

    function automatic logic [3:0] chanIdx(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] off;
        off = addr - base;
        return off[5:2];
    endfunction

    // Undervoltage pins are asynchronous; a change counts only once stages two and three agree.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            uvMeta <= 2'b11;
            uvSync <= 2'b11;
            uvLate <= 2'b11;
            uvFilt <= 2'b11;
        end else begin
            uvMeta <= {ldoUvPin, supplyUvPin};
            uvSync <= uvMeta;
            uvLate <= uvSync;
            for (int b = 0; b < 2; b++) begin
                if (uvSync[b] == uvLate[b]) begin
                    uvFilt[b] <= uvLate[b];
                end
            end
        end
    end
    assign uvActive = uvFilt[0] | uvFilt[1];

    // APB strobes; the slave never inserts wait states.
    assign wrEn = psel & penable & pwrite;
    assign wrCtrl = wrEn && (paddr == ADDR_CTRL) && (state != LDP_POR);
    assign clearFlagWrite = wrCtrl & pwdata[CTRL_FLAG_CLR_BIT];
    assign faultClearWrite = wrCtrl & pwdata[CTRL_FAULT_CLR_BIT];
    assign loadDefaults = (state == LDP_POR) | registerReloadCmd;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addrMapped;

    // Sequencer: reset state while either supply is low, then timed initialization, then normal.
    always_ff @(posedge core_clk) begin
        if (!rst_n || uvActive) begin
            state <= LDP_POR;
        end else begin
            case (state)
                LDP_POR: state <= LDP_INIT;
                LDP_INIT: begin
                    if (clearFlagWrite || unitsLeft == 4'h0) begin
                        state <= LDP_NORMAL;
                    end
                end
                LDP_NORMAL: state <= LDP_NORMAL;
                default: state <= LDP_POR;
            endcase
        end
    end

    // Initialization timer in units of INIT_UNIT_CYCLES; reloaded throughout the reset state.
    always_ff @(posedge core_clk) begin
        if (!rst_n || state == LDP_POR) begin
            unitCnt <= 16'h0000;
            unitsLeft <= initTimerLength;
        end else if (state == LDP_INIT && unitsLeft != 4'h0) begin
            if (unitCnt == 16'(INIT_UNIT_CYCLES - 1)) begin
                unitCnt <= 16'h0000;
                unitsLeft <= unitsLeft - 4'h1;
            end else begin
                unitCnt <= unitCnt + 16'h0001;
            end
        end
    end

    // Reset history flag; a set in the same cycle as a clear wins.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            porFlag <= 1'b1;
        end else if (loadDefaults) begin
            porFlag <= 1'b1;
        end else if (clearFlagWrite) begin
            porFlag <= 1'b0;
        end
    end

    // Reload command acts in the cycle after the write and then drops by itself.
    always_ff @(posedge core_clk) begin
        if (!rst_n || state == LDP_POR) begin
            registerReloadCmd <= 1'b0;
        end else begin
            registerReloadCmd <= wrCtrl & pwdata[CTRL_RELOAD_BIT];
        end
    end

    // Fault-clear pulse goes out to the other fault flags of the device.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            faultClearPulse <= 1'b0;
        end else begin
            faultClearPulse <= faultClearWrite;
        end
    end

    // Threshold code; setting 15 has no meaning of its own and acts as the highest setting.
    always_comb begin
        thresholdCode = LOW_SUP_BASE_CODE + LOW_SUP_STEP_CODE * 8'((lowSupplyThreshold > LOW_SUP_TH_MAX) ?
            LOW_SUP_TH_MAX : lowSupplyThreshold);
    end

    // Low-supply comparison on each fresh converter result; the warning is sticky.
    always_ff @(posedge core_clk) begin
        if (!rst_n || state == LDP_POR) begin
            lowSupplyNow <= 1'b0;
            lowSupplyWarningFlag <= 1'b0;
        end else begin
            if (supplyAdcValid) begin
                lowSupplyNow <= supplyAdcCode < thresholdCode;
            end
            if (supplyAdcValid && supplyAdcCode < thresholdCode) begin
                lowSupplyWarningFlag <= 1'b1;
            end else if (faultClearWrite) begin
                lowSupplyWarningFlag <= 1'b0;
            end
        end
    end
    assign diagSuppress = lowSupplyNow;

    // Configuration registers: nonvolatile copies or defaults on load, else software writes.
    always_ff @(posedge core_clk) begin
        if (!rst_n || loadDefaults) begin
            referenceGainSelect <= nvReferenceGain;
            dimmingFrequencySelect <= nvDimmingFrequency;
            lowSupplyThreshold <= nvLowSupplyThreshold;
            initTimerLength <= nvInitTimerLength;
            channelOutputEnable <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                channelCurrentCode[i] <= CURRENT_DEFAULT;
                dutyHigh[i] <= DUTY_HI_DEFAULT;
                dutyLow[i] <= DUTY_LO_DEFAULT;
            end
        end else if (wrEn) begin
            if (paddr == ADDR_CONF) begin
                referenceGainSelect <= pwdata[CONF_GAIN_LSB +: 2];
                dimmingFrequencySelect <= pwdata[CONF_FREQ_LSB +: 4];
                lowSupplyThreshold <= pwdata[CONF_TH_LSB +: 4];
            end else if (paddr == ADDR_ENABLE) begin
                channelOutputEnable <= pwdata[NUM_CH-1:0];
            end else if (chanHit(paddr, ADDR_CURR_BASE)) begin
                channelCurrentCode[chanIdx(paddr, ADDR_CURR_BASE)] <= pwdata[5:0];
            end else if (chanHit(paddr, ADDR_DUTY_BASE)) begin
                dutyHigh[chanIdx(paddr, ADDR_DUTY_BASE)] <= pwdata[DUTY_HI_LSB +: 8];
                dutyLow[chanIdx(paddr, ADDR_DUTY_BASE)] <= pwdata[DUTY_LO_LSB +: 4];
            end
        end
    end

    // Read decode; unmapped or unaligned addresses read zero and raise pslverr.
    always_comb begin
        readWord = 32'h0000_0000;
        addrMapped = 1'b1;
        if (paddr == ADDR_CTRL) begin
            readWord[CTRL_RELOAD_BIT] = registerReloadCmd;
        end else if (paddr == ADDR_STATUS) begin
            readWord[STAT_POR_BIT] = porFlag;
            readWord[STAT_LOWSUP_BIT] = lowSupplyWarningFlag;
            readWord[STAT_LOWNOW_BIT] = lowSupplyNow;
            readWord[STAT_STATE_LSB +: 3] = state;
        end else if (paddr == ADDR_CONF) begin
            readWord[CONF_GAIN_LSB +: 2] = referenceGainSelect;
            readWord[CONF_FREQ_LSB +: 4] = dimmingFrequencySelect;
            readWord[CONF_TH_LSB +: 4] = lowSupplyThreshold;
        end else if (paddr == ADDR_ENABLE) begin
            readWord[NUM_CH-1:0] = channelOutputEnable;
        end else if (chanHit(paddr, ADDR_CURR_BASE)) begin
            readWord[5:0] = channelCurrentCode[chanIdx(paddr, ADDR_CURR_BASE)];
        end else if (chanHit(paddr, ADDR_DUTY_BASE)) begin
            readWord[DUTY_HI_LSB +: 8] = dutyHigh[chanIdx(paddr, ADDR_DUTY_BASE)];
            readWord[DUTY_LO_LSB +: 4] = dutyLow[chanIdx(paddr, ADDR_DUTY_BASE)];
        end else begin
            addrMapped = 1'b0;
        end
    end

    // Read data is captured in the setup cycle so that it stands registered in the access phase.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= pwrite ? 32'h0000_0000 : readWord;
        end
    end

    // PWM timebase shared by all channels; 256 base ticks per period, 16 periods per dither frame.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            baseCnt <= 10'h000;
            cyclePos <= 8'h00;
            ditherFrame <= 4'h0;
        end else if (baseTick) begin
            baseCnt <= ldp_base_div(dimmingFrequencySelect) - 10'h001;
            cyclePos <= cyclePos + 8'h01;
            if (cyclePos == 8'hFF) begin
                ditherFrame <= ditherFrame + 4'h1;
            end
        end else begin
            baseCnt <= baseCnt - 10'h001;
        end
    end
    assign baseTick = (baseCnt == 10'h000);

    // Per-channel comparators; one base tick is 9 to 976 cycles long, so at the fastest rate a pulse can be shorter than MIN_PULSE_CYCLES.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            chanDrive <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                chanDrive[i] <= (state != LDP_POR) && !loadDefaults && channelOutputEnable[i] &&
                    ({1'b0, cyclePos} < ({1'b0, dutyHigh[i]} + 9'(ditherFrame <= dutyLow[i])));
            end
        end
    end

    // Analog settings handed to the current sources.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            currentMultiplier <= GAIN_X512;
            dimmingFrequency <= 4'h0;
            chanCurrentCodeOut <= '0;
            chanCurrentSteps <= '0;
        end else begin
            case (referenceGainSelect)
                2'b11: currentMultiplier <= GAIN_X512;
                2'b10: currentMultiplier <= GAIN_X256;
                2'b01: currentMultiplier <= GAIN_X128;
                default: currentMultiplier <= GAIN_X64;
            endcase
            dimmingFrequency <= dimmingFrequencySelect;
            for (int i = 0; i < NUM_CH; i++) begin
                chanCurrentCodeOut[6*i +: 6] <= channelCurrentCode[i];
                chanCurrentSteps[7*i +: 7] <= {1'b0, channelCurrentCode[i]} + 7'h01;
            end
        end
    end

    // Open-drain fault pin: only ever pulls low, and only in the reset state.
    assign faultPinOut = 1'b0;
    assign faultPinOe = (state == LDP_POR);
    property p_uv_forces_por;
        @(posedge core_clk) disable iff (!rst_n) uvActive |=> state == LDP_POR;
    endproperty
    a_uv_forces_por: assert property (p_uv_forces_por) else $error("Undervoltage did not force reset state.");
    property p_por_sets_flag;
        @(posedge core_clk) disable iff (!rst_n) state == LDP_POR |=> porFlag;
    endproperty
    a_por_sets_flag: assert property (p_por_sets_flag) else $error("History flag not set by reset state.");
    property p_por_outputs_off;
        @(posedge core_clk) disable iff (!rst_n) state == LDP_POR |=> chanDrive == '0 && channelOutputEnable == '0;
    endproperty
    a_por_outputs_off: assert property (p_por_outputs_off) else $error("Channel on during reset state.");
    property p_por_to_init;
        @(posedge core_clk) disable iff (!rst_n) state == LDP_POR && !uvActive |=> state == LDP_INIT && !faultPinOe;
    endproperty
    a_por_to_init: assert property (p_por_to_init) else $error("No move to initialization after supplies good.");
    property p_clear_ends_init;
        @(posedge core_clk) disable iff (!rst_n)
            state == LDP_INIT && clearFlagWrite && !uvActive |=> state == LDP_NORMAL && !porFlag;
    endproperty
    a_clear_ends_init: assert property (p_clear_ends_init) else $error("Flag clear did not end initialization.");
    property p_reload_self_clears;
        @(posedge core_clk) disable iff (!rst_n) registerReloadCmd |=> !registerReloadCmd && porFlag;
    endproperty
    a_reload_self_clears: assert property (p_reload_self_clears) else $error("Reload bit stuck or flag not set.");
    property p_low_supply_sets;
        @(posedge core_clk) disable iff (!rst_n)
            supplyAdcValid && supplyAdcCode < thresholdCode && state != LDP_POR && !uvActive
            |=> lowSupplyWarningFlag && diagSuppress;
    endproperty
    a_low_supply_sets: assert property (p_low_supply_sets) else $error("Low supply not flagged.");
    property p_low_supply_sticky;
        @(posedge core_clk) disable iff (!rst_n)
            lowSupplyWarningFlag && !faultClearWrite && state != LDP_POR && !uvActive |=> lowSupplyWarningFlag;
    endproperty
    a_low_supply_sticky: assert property (p_low_supply_sticky) else $error("Low-supply warning lost early.");
    property p_gain_map;
        @(posedge core_clk) disable iff (!rst_n)
            rst_n |=> currentMultiplier == ($past(referenceGainSelect) == 2'b11 ? GAIN_X512 :
            $past(referenceGainSelect) == 2'b10 ? GAIN_X256 :
            $past(referenceGainSelect) == 2'b01 ? GAIN_X128 : GAIN_X64);
    endproperty
    a_gain_map: assert property (p_gain_map) else $error("Wrong current multiplier.");
endmodule // ldp_power_seq
`default_nettype wire

// [ldp_host.sv]
// Host model: an APB master that issues register transfers to the sequencer.
`timescale 1ns/10ps
`default_nettype none
module ldp_host (
    input wire logic core_clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // The bus idles with no request so nothing is taken before reset ends.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer; it starts at the next rising edge, so two calls in a row leave one idle cycle
    // and no signal is driven twice in one time step. It returns at the edge where pready is seen.
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        output logic [31:0] rd, output logic err);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Leftover state from before a supply drop is wiped by a reload command.
    task automatic issueReload();
        logic [31:0] d;
        logic e;
        xfer(1'b1, 8'h00, 32'h0000_0002, d, e);
    endtask
endmodule // ldp_host
`default_nettype wire

// [testbench.sv]
// Self-checking testbench of the power-up sequencer.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ldp_pkg::*;
    localparam int UNIT = 4;
    // The fastest dimming setting spends nine clocks per base tick, 256 ticks per period.
    localparam int PWM_TICK = 9;
    localparam int PWM_PERIOD = 256 * PWM_TICK;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, diagSuppress, faultClearPulse, faultPinOut, faultPinOe;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r, x;
    logic e;
    logic supplyUvPin = 1'b1;
    logic ldoUvPin = 1'b1;
    logic [1:0] nvGain = 2'h0;
    logic [3:0] nvFreq = 4'h0;
    logic [3:0] nvTh = 4'h0;
    logic [3:0] nvInit = 4'h8;
    logic [7:0] supplyAdcCode = 8'hFF;
    logic supplyAdcValid = 1'b0;
    logic [11:0] chanDrive;
    logic [71:0] chanCurrentCodeOut;
    logic [83:0] chanCurrentSteps;
    logic [9:0] currentMultiplier;
    logic [3:0] dimmingFrequency;
    logic [31:0] seed = 32'h506A_8859;
    logic [31:0] gotQ[$];
    logic [31:0] expQ[$];
    int pending = 0;
    int fail_count = 0;
    int tests_run = 0;
    int i;
    int onCount;

    always #10 core_clk = ~core_clk;

    ldp_host host (.core_clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

    ldp_power_seq #(.INIT_UNIT_CYCLES(UNIT)) DUT (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .supplyUvPin, .ldoUvPin, .nvInitTimerLength(nvInit),
        .nvReferenceGain(nvGain), .nvDimmingFrequency(nvFreq), .nvLowSupplyThreshold(nvTh),
        .supplyAdcCode, .supplyAdcValid, .chanDrive, .chanCurrentCodeOut, .chanCurrentSteps,
        .currentMultiplier, .dimmingFrequency, .diagSuppress, .faultClearPulse, .faultPinOut, .faultPinOe);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic close_out();
        if (fail_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Notes a result with its expectation; the monitor below does the comparing.
    task automatic note(input logic [31:0] got, input logic [31:0] exp);
        gotQ.push_back(got);
        expQ.push_back(exp);
        pending++;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, r, e);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, r, e);
        note(r, exp);
    endtask

    // Polls the state field; the poll is bounded so a stuck sequencer shows up as mismatches.
    task automatic waitState(input logic [2:0] s);
        int n;
        n = 0;
        r = 32'h0;
        while (r[6:4] !== s && n < 200) begin
            host.xfer(1'b0, ADDR_STATUS, 32'h0, r, e);
            n++;
        end
        note(32'(r[6:4]), 32'(s));
    endtask

    // Reports a seen value that differs from its expectation.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Takes the oldest note off the queues whenever one is pending.
    always begin
        wait (pending > 0);
        pending--;
        check(gotQ.pop_front(), expQ.pop_front());
    end

    // Main sequence: power-up, configuration, reload, low supply, then undervoltage on each pin.
    initial begin
        @(posedge core_clk);
        x = rnd();
        nvGain <= x[1:0];
        nvFreq <= x[7:4];
        nvTh <= x[11:8];
        nvInit <= {1'b1, x[14:12]};
        supplyUvPin <= 1'b0;
        ldoUvPin <= 1'b0;
        repeat (3) @(posedge core_clk);
        note(32'(faultPinOe), 32'h1);
        note(32'(chanDrive), 32'h0);
        rst_n <= 1'b1;
        waitState(3'b010);
        note(32'(faultPinOe), 32'h0);
        rdChk(ADDR_STATUS, 32'h21);
        wr(ADDR_CTRL, 32'h1);
        rdChk(ADDR_STATUS, 32'h40);
        rdChk(ADDR_CONF, {20'h0, nvTh, nvFreq, 2'b00, nvGain});
        rdChk(ADDR_ENABLE, 32'h0);
        note(32'(dimmingFrequency), 32'(nvFreq));
        for (i = 0; i < 4; i++) begin
            wr(ADDR_CONF, {20'h0, nvTh, nvFreq, 2'b00, 2'(i)});
            repeat (2) @(posedge core_clk);
            note(32'(currentMultiplier), 32'd64 << i);
        end
        x = rnd();
        i = 32'(x[3:0]) % 12;
        wr(ADDR_CURR_BASE + 8'(4 * i), 32'(x[13:8]));
        wr(ADDR_ENABLE, 32'(x[27:16]));
        repeat (2) @(posedge core_clk);
        note(32'(chanCurrentSteps[7*i+:7]), 32'(x[13:8]) + 32'd1);
        note(32'(chanCurrentCodeOut[6*i+:6]), 32'(x[13:8]));
        rdChk(ADDR_ENABLE, 32'(x[27:16]));
        host.issueReload();
        repeat (2) @(posedge core_clk);
        note(32'(chanDrive), 32'h0);
        rdChk(ADDR_CTRL, 32'h0);
        rdChk(ADDR_ENABLE, 32'h0);
        rdChk(ADDR_STATUS, 32'h41);
        rdChk(ADDR_CONF, {20'h0, nvTh, nvFreq, 2'b00, nvGain});
        supplyAdcCode <= 8'h00;
        supplyAdcValid <= 1'b1;
        @(posedge core_clk);
        supplyAdcValid <= 1'b0;
        repeat (2) @(posedge core_clk);
        note(32'(diagSuppress), 32'h1);
        rdChk(ADDR_STATUS, 32'h47);
        supplyAdcCode <= 8'hFF;
        supplyAdcValid <= 1'b1;
        @(posedge core_clk);
        supplyAdcValid <= 1'b0;
        repeat (2) @(posedge core_clk);
        note(32'(diagSuppress), 32'h0);
        rdChk(ADDR_STATUS, 32'h43);
        wr(ADDR_CTRL, 32'h4);
        @(negedge core_clk);
        note(32'(faultClearPulse), 32'h1);
        @(posedge core_clk);
        rdChk(ADDR_STATUS, 32'h41);
        host.xfer(1'b0, 8'hFC, 32'h0, r, e);
        note(32'(e), 32'h1);
        // Fastest dimming rate, one channel on, random high duty byte, dithering off.
        wr(ADDR_CONF, {20'h0, nvTh, 4'hF, 2'b00, nvGain});
        wr(ADDR_DUTY_BASE + 8'(4 * i), {20'h0, x[31:24], 4'hF});
        wr(ADDR_ENABLE, 32'h1 << i);
        repeat (1000) @(posedge core_clk);
        onCount = 0;
        repeat (PWM_PERIOD) begin
            @(negedge core_clk);
            onCount += 32'(chanDrive[i]);
        end
        note(32'(onCount), (32'(x[31:24]) + 32'd1) * 32'(PWM_TICK));
        for (i = 0; i < 2; i++) begin
            wr(ADDR_CTRL, 32'h1);
            wr(ADDR_ENABLE, 32'h0000_0FFF);
            supplyUvPin <= (i == 0);
            ldoUvPin <= (i == 1);
            repeat (8) @(posedge core_clk);
            note(32'(faultPinOe), 32'h1);
            note(32'(chanDrive), 32'h0);
            supplyUvPin <= 1'b0;
            ldoUvPin <= 1'b0;
            waitState(3'b010);
            rdChk(ADDR_STATUS, 32'h21);
            repeat (32'(nvInit) * UNIT) @(posedge core_clk);
            rdChk(ADDR_STATUS, 32'h41);
            rdChk(ADDR_ENABLE, 32'h0);
            host.issueReload();
        end
        repeat (2) @(posedge core_clk);
        close_out();
    end

    // Watchdog sized well beyond the few thousand cycles the sequence needs.
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
endmodule // testbench
`default_nettype wire
